// file: scmi_cfg.svh
// named constants for the serial command interpreter
`ifndef SCMI_CFG_SVH
`define SCMI_CFG_SVH
// clock and millisecond timing
`define SCMI_CLK_PERIOD_NS 25
`define SCMI_MS_NS 1000000
`define SCMI_MS_CYCLES (`SCMI_MS_NS / `SCMI_CLK_PERIOD_NS)
// characters
`define SCMI_CHR_BANG 8'h21
`define SCMI_CHR_CR 8'h0D
`define SCMI_CHR_LF 8'h0A
`define SCMI_CHR_ZERO 8'h30
`define SCMI_CHR_NINE 8'h39
`define SCMI_CHR_A 8'h41
`define SCMI_CHR_Z 8'h5A
`define SCMI_DIGIT_HI 4'h3
// two-letter command codes
`define SCMI_CMD_KEY 16'h4B59
`define SCMI_CMD_BAUD 16'h4252
`define SCMI_CMD_ADDR 16'h4944
`define SCMI_CMD_TREQ 16'h5452
`define SCMI_CMD_TAUTO 16'h5454
`define SCMI_CMD_AVG 16'h4156
`define SCMI_CMD_DUP 16'h444D
`define SCMI_CMD_DELAY 16'h5244
`define SCMI_CMD_STORE 16'h4353
// parameter values (packed decimal)
`define SCMI_KEY_READ 20'h00000
`define SCMI_KEY_USER 20'h00001
`define SCMI_KEY_ADMIN 20'h04711
`define SCMI_STORE_YES 20'h00001
`define SCMI_ADDR_BCAST 8'h99
`define SCMI_ADDR_MAX 20'h00099
`define SCMI_BAUD_MIN 20'h00012
`define SCMI_BAUD_MAX 20'h01152
`define SCMI_DELAY_MAX 20'h00999
`define SCMI_DUP_HALF 4'h0
`define SCMI_DUP_BUS 4'h1
`define SCMI_DUP_P2P 4'h2
// defaults before the stored set is loaded
`define SCMI_DEF_ADDR 8'h00
`define SCMI_DEF_BAUD 20'h00096
`define SCMI_DEF_DUP 4'h0
`define SCMI_DEF_DELAY 12'h000
`define SCMI_DEF_AVG 20'h00001
`define SCMI_DEF_TSEL 20'h00000
// answer layout
`define SCMI_IDX_BANG 5'h00
`define SCMI_IDX_ADDR_HI 5'h01
`define SCMI_IDX_ADDR_LO 5'h02
`define SCMI_IDX_CMD_HI 5'h03
`define SCMI_IDX_CMD_LO 5'h04
`define SCMI_IDX_DIG0 5'h05
`define SCMI_IDX_DIG4 5'h09
`define SCMI_IDX_CR1 5'h0A
`define SCMI_IDX_TEXT 5'h0C
`define SCMI_TAIL_LEN 5'h02
`define SCMI_VAL_TOP 5'h10
`define SCMI_TXT_TOP 7'h58
`define SCMI_TXT_READ "READ ONLY   "
`define SCMI_TXT_USER "USER ACCESS "
`define SCMI_TXT_ADMIN "ADMIN ACCESS"
`define SCMI_TLEN_READ 5'h09
`define SCMI_TLEN_USER 5'h0B
`define SCMI_TLEN_ADMIN 5'h0C
// receive buffer positions
`define SCMI_RX_ADDR_END 4'h2
`define SCMI_RX_HDR_LEN 4'h4
`define SCMI_RX_MAX_LEN 4'h9
`define SCMI_RX_SAT 4'hF
// register port map
`define SCMI_REG_CTRL 4'h0
`define SCMI_REG_DELAY 4'h1
`define SCMI_REG_STATUS 4'h2
`define SCMI_REG_BAUD 4'h3
`define SCMI_CTRL_RST 1'h1
`endif

// file: scmi_host.sv
// far-side model: polling master, answer serialiser and telegram sender
module scmi_host import scmi_pkg::*; (
  input wire logic i_clk,
  input wire scmi_byte_type i_tx,
  input wire logic i_tlg_start,
  input wire logic [19:0] i_tlg_num,
  output scmi_byte_type o_rx,
  output logic o_tx_ready,
  output logic o_tx_idle,
  output logic o_tlg_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  logic [19:0] tlg_num = 20'h00000;
  int tlg_cnt = 0;
  int hold = 0;
  initial begin
    o_rx = '0;
    o_tx_ready = 1'b0;
    o_tx_idle = 1'b1;
    o_tlg_done = 1'b0;
  end
  // serialiser takes a byte, then shifts it out for a few cycles
  always @(posedge i_clk) begin
    o_tlg_done <= i_tlg_start;
    if (i_tlg_start) begin
      tlg_num <= i_tlg_num;
      tlg_cnt <= tlg_cnt + 1;
    end
    if (i_tx.valid && o_tx_ready) begin
      got.push_back(i_tx.data);
      hold <= 3;
      o_tx_ready <= 1'b0;
      o_tx_idle <= 1'b0;
    end else begin
      hold <= (hold > 0) ? hold - 1 : 0;
      o_tx_ready <= (hold <= 1);
      o_tx_idle <= (hold == 0);
    end
  end
  // the master alone starts traffic, one station address at a time
  task automatic send(input string s);
    for (int k = 0; k < s.len(); k++) begin
      @(posedge i_clk);
      o_rx <= {1'b1, s[k]};
      @(posedge i_clk);
      o_rx <= {1'b0, ~s[k]};
    end
  endtask
endmodule

// file: scmi_interp.sv
// serial command interpreter: parse, gate, apply, answer, driver control
`include "scmi_cfg.svh"
module scmi_interp import scmi_pkg::*; #(
  parameter int unsigned MS_CYCLES = `SCMI_MS_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire scmi_byte_type i_rx,
  input wire logic i_tx_ready,
  input wire logic i_tx_idle,
  output scmi_byte_type o_tx,
  output logic o_drv_en,
  output logic o_aout_en,
  output logic o_tlg_start,
  output logic [19:0] o_tlg_num,
  input wire logic i_tlg_done,
  output logic [19:0] o_baud_bcd,
  output logic o_nv_we,
  output scmi_nv_type o_nv_data,
  input wire scmi_nv_type i_nv_data,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata
);
  logic rst_meta_q, rst_n, load_q, ctrl_en_q, tmr_start_q, tmr_done;
  logic [3:0] rx_cnt_q, dup_q;
  logic rx_bad_q, rx_cr, hit, is_query, known, value_ok, accept, store_now;
  logic [7:0] rx_addr_q, addr_q, resp_addr_q;
  logic [15:0] rx_cmd_q, resp_cmd_q;
  logic [19:0] rx_par_q, baud_cfg_q, avg_q, tsel_q, cur_val, resp_val_q;
  logic [11:0] delay_q;
  logic [9:0] ms_bin;
  logic [4:0] idx_q, resp_len, tlen, rel;
  logic [2:0] dig;
  logic [6:0] txt_bit;
  logic [95:0] txt;
  logic [7:0] cur_byte;
  logic resp_txt_q, resp_tlg_q, baud_apply_q;
  scmi_level_type level_q, need_lvl, key_lvl, resp_lvl_q;
  scmi_state_type state_q;

  // reset release through two flops
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // one cycle after release the stored set is taken in
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_q <= 1'b1;
    end else begin
      load_q <= 1'b0;
    end
  end

  // receive buffer: address digits, command letters, parameter digits
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt_q <= 4'h0;
      rx_bad_q <= 1'b0;
      rx_addr_q <= 8'h00;
      rx_cmd_q <= 16'h0000;
      rx_par_q <= 20'h00000;
    end else if (i_rx.valid) begin
      if (rx_cr) begin
        rx_cnt_q <= 4'h0;
        rx_bad_q <= 1'b0;
        rx_par_q <= 20'h00000;
      end else begin
        if (rx_cnt_q != `SCMI_RX_SAT) begin
          rx_cnt_q <= rx_cnt_q + 4'h1;
        end
        if (rx_cnt_q < `SCMI_RX_ADDR_END) begin
          rx_addr_q <= {rx_addr_q[3:0], i_rx.data[3:0]};
          if (i_rx.data < `SCMI_CHR_ZERO || i_rx.data > `SCMI_CHR_NINE) begin
            rx_bad_q <= 1'b1;
          end
        end else if (rx_cnt_q < `SCMI_RX_HDR_LEN) begin
          rx_cmd_q <= {rx_cmd_q[7:0], i_rx.data};
          if (i_rx.data < `SCMI_CHR_A || i_rx.data > `SCMI_CHR_Z) begin
            rx_bad_q <= 1'b1;
          end
        end else if (rx_cnt_q < `SCMI_RX_MAX_LEN) begin
          rx_par_q <= {rx_par_q[15:0], i_rx.data[3:0]};
          if (i_rx.data < `SCMI_CHR_ZERO || i_rx.data > `SCMI_CHR_NINE) begin
            rx_bad_q <= 1'b1;
          end
        end else begin
          rx_bad_q <= 1'b1;
        end
      end
    end
  end

  // request decode, privilege and value checks
  always_comb begin
    rx_cr = i_rx.data == `SCMI_CHR_CR;
    hit = i_rx.valid && rx_cr && state_q == SCMI_ST_IDLE && ctrl_en_q && !rx_bad_q &&
      rx_cnt_q >= `SCMI_RX_HDR_LEN &&
      (rx_addr_q == addr_q || rx_addr_q == `SCMI_ADDR_BCAST);
    is_query = rx_cnt_q == `SCMI_RX_HDR_LEN;
    key_lvl = SCMI_LVL_READ;
    if (rx_par_q == `SCMI_KEY_ADMIN) begin
      key_lvl = SCMI_LVL_ADMIN;
    end else if (rx_par_q == `SCMI_KEY_USER) begin
      key_lvl = SCMI_LVL_USER;
    end
    need_lvl = SCMI_LVL_READ;
    known = 1'b1;
    value_ok = 1'b1;
    cur_val = 20'h00000;
    case (rx_cmd_q)
      `SCMI_CMD_KEY: begin
        cur_val = level_q == SCMI_LVL_ADMIN ? `SCMI_KEY_ADMIN :
          (level_q == SCMI_LVL_USER ? `SCMI_KEY_USER : `SCMI_KEY_READ);
        value_ok = rx_par_q == `SCMI_KEY_READ || rx_par_q == `SCMI_KEY_USER ||
          rx_par_q == `SCMI_KEY_ADMIN;
      end
      `SCMI_CMD_BAUD: begin
        need_lvl = SCMI_LVL_ADMIN;
        cur_val = baud_cfg_q;
        value_ok = rx_par_q >= `SCMI_BAUD_MIN && rx_par_q <= `SCMI_BAUD_MAX;
      end
      `SCMI_CMD_ADDR: begin
        need_lvl = SCMI_LVL_ADMIN;
        cur_val = {12'h000, addr_q};
        value_ok = rx_par_q <= `SCMI_ADDR_MAX;
      end
      `SCMI_CMD_DUP: begin
        need_lvl = SCMI_LVL_ADMIN;
        cur_val = {16'h0000, dup_q};
        value_ok = rx_par_q <= {16'h0000, `SCMI_DUP_P2P};
      end
      `SCMI_CMD_DELAY: begin
        need_lvl = SCMI_LVL_USER;
        cur_val = {8'h00, delay_q};
        value_ok = rx_par_q <= `SCMI_DELAY_MAX;
      end
      `SCMI_CMD_AVG: begin
        need_lvl = SCMI_LVL_USER;
        cur_val = avg_q;
      end
      `SCMI_CMD_TAUTO: begin
        need_lvl = SCMI_LVL_USER;
        cur_val = tsel_q;
      end
      `SCMI_CMD_STORE: need_lvl = SCMI_LVL_USER;
      `SCMI_CMD_TREQ: cur_val = rx_par_q;
      default: known = 1'b0;
    endcase
    accept = hit && known && (is_query || (value_ok && level_q >= need_lvl));
    store_now = accept && !is_query &&
      ((rx_cmd_q == `SCMI_CMD_KEY && rx_par_q == `SCMI_KEY_READ) ||
      (rx_cmd_q == `SCMI_CMD_STORE && rx_par_q == `SCMI_STORE_YES));
  end

  // working parameter set and access level
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= SCMI_LVL_READ;
      addr_q <= `SCMI_DEF_ADDR;
      baud_cfg_q <= `SCMI_DEF_BAUD;
      dup_q <= `SCMI_DEF_DUP;
      delay_q <= `SCMI_DEF_DELAY;
      avg_q <= `SCMI_DEF_AVG;
      tsel_q <= `SCMI_DEF_TSEL;
    end else if (load_q) begin
      addr_q <= i_nv_data.addr;
      baud_cfg_q <= i_nv_data.baud;
      dup_q <= i_nv_data.duplex;
      delay_q <= i_nv_data.delay;
      avg_q <= i_nv_data.avg;
    end else begin
      if (i_wr && i_addr == `SCMI_REG_DELAY) begin
        delay_q <= i_wdata[11:0];
      end
      if (accept && !is_query) begin
        case (rx_cmd_q)
          `SCMI_CMD_KEY: level_q <= key_lvl;
          `SCMI_CMD_ADDR: addr_q <= rx_par_q[7:0];
          `SCMI_CMD_BAUD: baud_cfg_q <= rx_par_q;
          `SCMI_CMD_DUP: dup_q <= rx_par_q[3:0];
          `SCMI_CMD_DELAY: delay_q <= rx_par_q[11:0];
          `SCMI_CMD_AVG: avg_q <= rx_par_q;
          `SCMI_CMD_TAUTO: tsel_q <= rx_par_q;
          default: ;
        endcase
      end
    end
  end

  // non-volatile write request and active line rate
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_nv_we <= 1'b0;
      o_nv_data <= '0;
      o_baud_bcd <= `SCMI_DEF_BAUD;
    end else begin
      o_nv_we <= store_now;
      o_nv_data <= {addr_q, baud_cfg_q, dup_q, delay_q, avg_q};
      if (load_q) begin
        o_baud_bcd <= i_nv_data.baud;
      end else if (state_q == SCMI_ST_DRAIN && i_tx_idle && baud_apply_q) begin
        o_baud_bcd <= baud_cfg_q;
      end
    end
  end

  // answer byte at the current index
  always_comb begin
    txt = `SCMI_TXT_READ;
    tlen = `SCMI_TLEN_READ;
    case (resp_lvl_q)
      SCMI_LVL_USER: begin
        txt = `SCMI_TXT_USER;
        tlen = `SCMI_TLEN_USER;
      end
      SCMI_LVL_ADMIN: begin
        txt = `SCMI_TXT_ADMIN;
        tlen = `SCMI_TLEN_ADMIN;
      end
      default: ;
    endcase
    resp_len = resp_txt_q ? `SCMI_IDX_TEXT + tlen + `SCMI_TAIL_LEN : `SCMI_IDX_TEXT;
    rel = idx_q - `SCMI_IDX_TEXT;
    dig = 3'(idx_q - `SCMI_IDX_DIG0);
    txt_bit = `SCMI_TXT_TOP - {rel[3:0], 3'b000};
    cur_byte = `SCMI_CHR_LF;
    if (idx_q == `SCMI_IDX_BANG) begin
      cur_byte = `SCMI_CHR_BANG;
    end else if (idx_q == `SCMI_IDX_ADDR_HI) begin
      cur_byte = {`SCMI_DIGIT_HI, resp_addr_q[7:4]};
    end else if (idx_q == `SCMI_IDX_ADDR_LO) begin
      cur_byte = {`SCMI_DIGIT_HI, resp_addr_q[3:0]};
    end else if (idx_q == `SCMI_IDX_CMD_HI) begin
      cur_byte = resp_cmd_q[15:8];
    end else if (idx_q == `SCMI_IDX_CMD_LO) begin
      cur_byte = resp_cmd_q[7:0];
    end else if (idx_q <= `SCMI_IDX_DIG4) begin
      cur_byte = {`SCMI_DIGIT_HI, resp_val_q[`SCMI_VAL_TOP - {dig, 2'b00} +: 4]};
    end else if (idx_q == `SCMI_IDX_CR1) begin
      cur_byte = `SCMI_CHR_CR;
    end else if (idx_q >= `SCMI_IDX_TEXT) begin
      if (rel < tlen) begin
        cur_byte = txt[txt_bit +: 8];
      end else if (rel == tlen) begin
        cur_byte = `SCMI_CHR_CR;
      end
    end
    ms_bin = 10'(delay_q[11:8]) * 10'h064 + 10'(delay_q[7:4]) * 10'h00A + 10'(delay_q[3:0]);
  end

  // answer hold-off timer
  scmi_ms_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_timer (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_start(tmr_start_q),
    .i_ms(ms_bin),
    .o_done(tmr_done)
  );

  // answer sequencer
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SCMI_ST_IDLE;
      idx_q <= 5'h00;
      resp_addr_q <= 8'h00;
      resp_cmd_q <= 16'h0000;
      resp_val_q <= 20'h00000;
      resp_txt_q <= 1'b0;
      resp_lvl_q <= SCMI_LVL_READ;
      resp_tlg_q <= 1'b0;
      baud_apply_q <= 1'b0;
      tmr_start_q <= 1'b0;
      o_tx <= '0;
      o_tlg_start <= 1'b0;
      o_tlg_num <= 20'h00000;
    end else begin
      tmr_start_q <= 1'b0;
      o_tlg_start <= 1'b0;
      case (state_q)
        SCMI_ST_IDLE: begin
          if (accept) begin
            state_q <= SCMI_ST_DELAY;
            tmr_start_q <= 1'b1;
            resp_addr_q <= addr_q;
            resp_cmd_q <= rx_cmd_q;
            resp_val_q <= is_query ? cur_val : rx_par_q;
            resp_txt_q <= rx_cmd_q == `SCMI_CMD_KEY && !is_query;
            resp_lvl_q <= key_lvl;
            resp_tlg_q <= rx_cmd_q == `SCMI_CMD_TREQ ||
              (rx_cmd_q == `SCMI_CMD_TAUTO && !is_query);
            baud_apply_q <= rx_cmd_q == `SCMI_CMD_BAUD && !is_query;
            o_tlg_num <= rx_par_q;
          end
        end
        SCMI_ST_DELAY: begin
          idx_q <= 5'h00;
          if (tmr_done) begin
            state_q <= resp_tlg_q ? SCMI_ST_TLG : SCMI_ST_SEND;
            o_tlg_start <= resp_tlg_q;
          end
        end
        SCMI_ST_SEND: begin
          if (!o_tx.valid) begin
            o_tx <= {1'b1, cur_byte};
          end else if (i_tx_ready) begin
            o_tx.valid <= 1'b0;
            if (idx_q == resp_len - 5'h01) begin
              state_q <= SCMI_ST_DRAIN;
            end else begin
              idx_q <= idx_q + 5'h01;
            end
          end
        end
        SCMI_ST_TLG: begin
          if (i_tlg_done) begin
            state_q <= SCMI_ST_DRAIN;
          end
        end
        SCMI_ST_DRAIN: begin
          if (i_tx_idle) begin
            state_q <= SCMI_ST_IDLE;
          end
        end
        default: state_q <= SCMI_ST_IDLE;
      endcase
    end
  end

  // line driver and shared analogue pins
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_drv_en <= 1'b0;
      o_aout_en <= 1'b0;
    end else begin
      o_drv_en <= dup_q == `SCMI_DUP_P2P || state_q == SCMI_ST_SEND ||
        state_q == SCMI_ST_TLG || state_q == SCMI_ST_DRAIN;
      o_aout_en <= dup_q == `SCMI_DUP_HALF;
    end
  end

  // register port: control write and read-back
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_en_q <= `SCMI_CTRL_RST;
      o_rdata <= 32'h00000000;
    end else begin
      if (i_wr && i_addr == `SCMI_REG_CTRL) begin
        ctrl_en_q <= i_wdata[0];
      end
      o_rdata <= 32'h00000000;
      if (i_rd) begin
        case (i_addr)
          `SCMI_REG_CTRL: o_rdata <= {31'h0000000, ctrl_en_q};
          `SCMI_REG_DELAY: o_rdata <= {20'h00000, delay_q};
          `SCMI_REG_STATUS: o_rdata <= {17'h0000, state_q != SCMI_ST_IDLE, level_q, dup_q, addr_q};
          `SCMI_REG_BAUD: o_rdata <= {12'h000, o_baud_bcd};
          default: o_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  default clocking scmi_cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_n);

  AST_DRV_OFF_IDLE: assert property (
    (state_q == SCMI_ST_IDLE && $past(state_q) == SCMI_ST_IDLE && $past(dup_q) != `SCMI_DUP_P2P)
    |-> !o_drv_en)
    else $error("driver enabled outside an answer");
  AST_DRV_P2P: assert property (
    ($past(dup_q) == `SCMI_DUP_P2P && !$past(load_q)) |-> o_drv_en)
    else $error("point-to-point driver not held on");
  AST_AOUT: assert property (
    !$past(load_q) |-> (o_aout_en == ($past(dup_q) == `SCMI_DUP_HALF)))
    else $error("analogue enable disagrees with duplex");
  AST_BUF_CLEAR: assert property (
    (i_rx.valid && rx_cr) |=> (rx_cnt_q == 4'h0 && !rx_bad_q))
    else $error("buffer not emptied after carriage return");
  AST_FOREIGN: assert property (
    (i_rx.valid && rx_cr && state_q == SCMI_ST_IDLE && rx_addr_q != addr_q &&
    rx_addr_q != `SCMI_ADDR_BCAST) |=> state_q == SCMI_ST_IDLE)
    else $error("answered a foreign address");
  AST_LEVEL_GATE: assert property (
    (hit && !is_query && rx_cmd_q == `SCMI_CMD_BAUD && level_q != SCMI_LVL_ADMIN)
    |=> $stable(baud_cfg_q))
    else $error("admin setting changed without admin level");
  AST_KEY_ADMIN: assert property (
    (accept && !is_query && rx_cmd_q == `SCMI_CMD_KEY && rx_par_q == `SCMI_KEY_ADMIN)
    |=> level_q == SCMI_LVL_ADMIN)
    else $error("admin key did not grant admin level");
  AST_STORE: assert property (
    (accept && !is_query && rx_cmd_q == `SCMI_CMD_KEY && rx_par_q == `SCMI_KEY_READ)
    |=> o_nv_we ##1 !o_nv_we)
    else $error("key reset did not store once");
  AST_FIRST_BYTE: assert property (
    (state_q == SCMI_ST_DELAY && tmr_done && !resp_tlg_q)
    |-> ##2 (o_tx.valid && o_tx.data == `SCMI_CHR_BANG && o_drv_en))
    else $error("answer did not open with bang");
  AST_BAUD_LATE: assert property (
    $changed(o_baud_bcd) |-> ($past(state_q) == SCMI_ST_DRAIN || $past(load_q)))
    else $error("line rate changed before echo ended");
endmodule

// file: scmi_ms_timer.sv
// millisecond delay timer for the answer hold-off
`include "scmi_cfg.svh"
module scmi_ms_timer #(
  parameter int unsigned MS_CYCLES = `SCMI_MS_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [9:0] i_ms,
  output logic o_done
);
  logic [15:0] cyc_q;
  logic [9:0] ms_q;
  logic run_q;

  // count whole milliseconds, then pulse done once
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cyc_q <= 16'h0000;
      ms_q <= 10'h000;
      run_q <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        run_q <= 1'b1;
        ms_q <= i_ms;
        cyc_q <= 16'h0000;
      end else if (run_q) begin
        if (ms_q == 10'h000) begin
          run_q <= 1'b0;
          o_done <= 1'b1;
        end else if (cyc_q == 16'(MS_CYCLES - 1)) begin
          cyc_q <= 16'h0000;
          ms_q <= ms_q - 10'h001;
        end else begin
          cyc_q <= cyc_q + 16'h0001;
        end
      end
    end
  end
endmodule

// file: scmi_pkg.sv
// types shared by the serial command interpreter files
package scmi_pkg;
  typedef enum logic [2:0] {
    SCMI_ST_IDLE = 3'h0,
    SCMI_ST_DELAY = 3'h1,
    SCMI_ST_SEND = 3'h3,
    SCMI_ST_DRAIN = 3'h2,
    SCMI_ST_TLG = 3'h6
  } scmi_state_type;
  typedef enum logic [1:0] {
    SCMI_LVL_READ = 2'h0,
    SCMI_LVL_USER = 2'h1,
    SCMI_LVL_ADMIN = 2'h2
  } scmi_level_type;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } scmi_byte_type;
  typedef struct packed {
    logic [7:0] addr;
    logic [19:0] baud;
    logic [3:0] duplex;
    logic [11:0] delay;
    logic [19:0] avg;
  } scmi_nv_type;
endpackage

// file: tb_top.sv
// self-checking bench for the serial command interpreter
module tb_top;
  import scmi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_tx_ready, i_tx_idle, i_tlg_done, o_drv_en, o_aout_en, o_tlg_start, o_nv_we;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata, v;
  logic [19:0] o_tlg_num, o_baud_bcd;
  scmi_byte_type i_rx, o_tx;
  scmi_nv_type o_nv_data;
  scmi_nv_type i_nv_data = '{8'h00, 20'h00096, 4'h0, 12'h000, 20'h00001};
  int n_errors = 0;
  int comparisons = 0;
  int we_cnt = 0;
  int drv_cnt = 0;
  int t0, t2, c;
  string req_s[13] = '{"00BR\r", "00KY1\r", "00AV5\r", "00BR1152\r", "00KY4711\r",
    "00AV7\r", "00ID4\r", "00AV\r", "99AV\r", "Z\r04DM\r", "04KY0\r", "04KY1\r", "04AV9\r"};
  string exp_s[13] = '{"!00BR00096\r\n", "!00KY00001\r\nUSER ACCESS\r\n", "!00AV00005\r\n", "",
    "!00KY04711\r\nADMIN ACCESS\r\n", "!00AV00007\r\n", "!00ID00004\r\n", "", "!04AV00007\r\n",
    "!04DM00000\r\n", "!04KY00000\r\nREAD ONLY\r\n", "!04KY00001\r\nUSER ACCESS\r\n",
    "!04AV00009\r\n"};
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  scmi_interp #(.MS_CYCLES(4)) dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_rx(i_rx),
    .i_tx_ready(i_tx_ready), .i_tx_idle(i_tx_idle), .o_tx(o_tx), .o_drv_en(o_drv_en),
    .o_aout_en(o_aout_en), .o_tlg_start(o_tlg_start), .o_tlg_num(o_tlg_num),
    .i_tlg_done(i_tlg_done), .o_baud_bcd(o_baud_bcd), .o_nv_we(o_nv_we),
    .o_nv_data(o_nv_data), .i_nv_data(i_nv_data), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
  scmi_host host (.i_clk(i_clk), .i_tx(o_tx), .i_tlg_start(o_tlg_start),
    .i_tlg_num(o_tlg_num), .o_rx(i_rx), .o_tx_ready(i_tx_ready), .o_tx_idle(i_tx_idle),
    .o_tlg_done(i_tlg_done));
  // non-volatile store model, plus counts of store pulses and driver cycles
  always @(posedge i_clk) begin
    if (o_nv_we === 1'b1) begin
      i_nv_data <= o_nv_data;
    end
    we_cnt <= we_cnt + (o_nv_we === 1'b1);
    drv_cnt <= drv_cnt + (o_drv_en === 1'b1);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_ans(input string exp);
    chk(host.got.size(), exp.len(), "answer length");
    for (int k = 0; k < exp.len() && k < host.got.size(); k++) begin
      chk(host.got[k], exp[k], "answer byte");
    end
    host.got.delete();
  endtask
  // wait until the driver has been off for a while, bounded
  task automatic settle();
    int q;
    q = 0;
    for (int k = 0; k < 600 && q < 40; k++) begin
      @(posedge i_clk);
      q = (o_drv_en === 1'b0) ? q + 1 : 0;
    end
  endtask
  task automatic req(input string s, input string exp);
    int d;
    d = drv_cnt;
    host.send(s);
    settle();
    chk_ans(exp);
    chk(drv_cnt != d, exp.len() != 0, "driver use");
  endtask
  task automatic lat(input string s, output int n);
    host.send(s);
    for (n = 0; n < 2000 && o_tx.valid !== 1'b1; n++) begin
      @(posedge i_clk);
    end
    settle();
    host.got.delete();
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #(80000 * 25);
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    rd(4'h2, v);
    chk(v[13:12], 2'h0, "level after power-up");
    for (int i = 0; i < 13; i++) begin
      req(req_s[i], exp_s[i]);
    end
    chk(we_cnt, 1, "store pulses");
    chk(i_nv_data.addr, 8'h04, "stored address");
    $display("test table done");
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    rd(4'h2, v);
    chk(v[13:12], 2'h0, "level after restart");
    req("04AV\r", "!04AV00007\r\n");
    req("04AV3\r", "");
    $display("test restart done");
    lat("04AV\r", t0);
    req("04KY1\r", "!04KY00001\r\nUSER ACCESS\r\n");
    req("04RD2\r", "!04RD00002\r\n");
    lat("04AV\r", t2);
    chk(t2 - t0, 8, "response delay");
    chk(t0, 5, "prompt answer");
    wr(4'h1, 32'h123);
    rd(4'h1, v);
    chk(v[11:0], 12'h123, "delay register");
    wr(4'h1, 32'h0);
    rd(4'h1, v);
    chk(v[11:0], 12'h000, "delay register");
    $display("test delay done");
    c = host.tlg_cnt;
    host.send("04TR2\r");
    settle();
    chk(host.tlg_cnt - c, 1, "telegram starts");
    chk(host.tlg_num, 20'h00002, "telegram number");
    chk_ans("");
    host.send("04TT3\r");
    settle();
    chk(host.tlg_cnt - c, 2, "auto telegram starts");
    chk(host.tlg_num, 20'h00003, "auto telegram number");
    chk_ans("");
    req("04TT\r", "!04TT00003\r\n");
    c = we_cnt;
    req("04CS0\r", "!04CS00000\r\n");
    req("04CS1\r", "!04CS00001\r\n");
    chk(we_cnt - c, 1, "store command");
    $display("test telegram done");
    req("04KY4711\r", "!04KY04711\r\nADMIN ACCESS\r\n");
    req("04BR1152\r", "!04BR01152\r\n");
    chk(o_baud_bcd, 20'h01152, "active rate");
    rd(4'h3, v);
    chk(v[19:0], 20'h01152, "rate register");
    for (int d = 2; d >= 0; d--) begin
      req($sformatf("04DM%0d\r", d), $sformatf("!04DM0000%0d\r\n", d));
      chk(o_drv_en, d == 2, "driver at rest");
      chk(o_aout_en, d == 0, "analogue pins");
    end
    $display("test duplex done");
    rd(4'h9, v);
    chk(v, 32'h0, "unmapped read");
    wr(4'h0, 32'h0);
    req("04AV\r", "");
    wr(4'h0, 32'h1);
    req("04AV\r", "!04AV00007\r\n");
    $display("test registers done");
    end_of_test();
  end
endmodule
